// ==== logic/rcrb_regs.svh ====
// Register map, field positions, reset values and pin timing of the radio configuration register bank.
// Assumes inclusion by bare name from the package, from the bank module and from the bench top.
`ifndef RCRB_REGS_SVH
`define RCRB_REGS_SVH

// Register count and widths
`define RCRB_REG_WIDTH 8
`define RCRB_ADDR_WIDTH 7
`define RCRB_NUM_REGS 23
`define RCRB_NUM_WR_REGS 22

// Offsets of the named registers
`define RCRB_RADIO_MODE_CTRL 7'h00
`define RCRB_MODULATION_FILTER_CTRL 7'h01
`define RCRB_BYPASS_OUTPUT_SELECT 7'h02
`define RCRB_VCO_BIAS_CTRL 7'h03
`define RCRB_MODULATION_SHAPE_CTRL 7'h04
`define RCRB_MODULATION_AMPLITUDE 7'h05
`define RCRB_CLOCK_SELECT_A 7'h06
`define RCRB_BITRATE_REFDIV_CTRL 7'h07
`define RCRB_SWITCHED_CAP_CLOCK_DIV 7'h08
`define RCRB_CRYSTAL_TUNE 7'h09
`define RCRB_SYNTH_A_SET0 7'h0a
`define RCRB_SYNTH_N_SET0_HIGH 7'h0b
`define RCRB_SYNTH_N_SET0_LOW 7'h0c
`define RCRB_SYNTH_M_SET0_HIGH 7'h0d
`define RCRB_SYNTH_M_SET0_LOW 7'h0e
`define RCRB_SYNTH_A_SET1 7'h0f
`define RCRB_SYNTH_N_SET1_HIGH 7'h10
`define RCRB_SYNTH_N_SET1_LOW 7'h11
`define RCRB_SYNTH_M_SET1_HIGH 7'h12
`define RCRB_SYNTH_M_SET1_LOW 7'h13
`define RCRB_FIXED_PATTERN_REG 7'h14
`define RCRB_FREQ_ERROR_CONTROL 7'h15
`define RCRB_FREQ_ERROR_RESULT 7'h16
`define RCRB_LAST_WR_ADDR 7'h15
`define RCRB_ADDR_SATURATE 7'h7f

// Fields of radio_mode_ctrl
`define RCRB_LOAD_EN_BIT 0
`define RCRB_MODE_LSB 1
`define RCRB_MODE_MSB 2

// Reset values: all zero apart from the mode field, which a parameter sets
`define RCRB_REG_RESET 8'h00
`define RCRB_READ_FILL 8'h00

// Used bits of registers 21 down to 0; unused bits never reach cfgRegs, though serial reads return them
`define RCRB_USED_MASK 176'h0fffff0fff0f3fff0fff0f3fffffff7f3fffffffffff

// Bit counter limit within one octet and synchroniser depth
`define RCRB_LAST_BIT 3'h7
`define RCRB_SYNC_STAGES 2

`endif

// ==== logic/rcrb_pkg.sv ====
// Types shared by the radio configuration register bank.
// Assumes rcrb_regs.svh is on the include path.
`default_nettype none
`include "rcrb_regs.svh"

package rcrb_pkg;

  // Phase of a serial control sequence
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_ADDR  = 2'b01,
    PH_WRITE = 2'b10,
    PH_READ  = 2'b11
  } rcrb_phase_t;

  typedef logic [`RCRB_NUM_WR_REGS-1:0][`RCRB_REG_WIDTH-1:0] rcrb_regs_t;
  typedef logic [`RCRB_REG_WIDTH-1:0] rcrb_byte_t;
  typedef logic [`RCRB_ADDR_WIDTH-1:0] rcrb_addr_t;

  // Whole state of the bank
  typedef struct packed {
    rcrb_phase_t phase;
    logic sclkPrev;
    logic csPrev;
    logic [2:0] bitCnt;
    rcrb_addr_t addr;
    rcrb_byte_t rxShift;
    rcrb_byte_t txShift;
    logic ioOe;
    logic wrote;
    logic loadPulse;
    rcrb_regs_t shadow;
    rcrb_regs_t active;
  } rcrb_state_t;

endpackage

`default_nettype wire

// ==== logic/rcrb_sync.sv ====
// Two-stage synchroniser for pins that toggle outside the system clock.
// Assumes nothing reads the first stage; only the second stage leaves.
`timescale 1ns/1ps
`default_nettype none

module rcrb_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  // Metastability filter; reset clears both stages to idle low
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      stage1_q <= '0;
      stage2_q <= '0;
    end
    else
    begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;

endmodule

`default_nettype wire

// ==== logic/rcrb_bank.sv ====
// Configuration register bank behind a three-wire serial control port (clock, data, select).
// Assumes the host makes the serial clock well below sys_clk / 4 and that freqErrResult is on sys_clk.
//
// Behaviour
// [RL1] Twenty-three eight-bit registers at consecutive addresses from zero.
// [RL2] All registers readable; 0 to 21 writable, register 22 read-only.
// [RL3] Every access moves a whole octet in either direction.
// [RL4] Unused register bits never reach the configuration outputs.
// [RL5] Host writes the fixed mandatory values into reserved bit positions.
// [RL6] Registers reached only through serial clock, data and select pins.
// [RL7] Host makes the serial clock at any rate; device never drives it. The bank needs it well below sys_clk / 4.
// [RL8] Serial clock edges ignored while select is inactive.
// [RL9] Shared clock and data lines; respond only under own select.
// [RL10] Battery reset puts the device into power-down mode by itself.
// [RL11] Host programs all writable registers once after battery reset.
// [RL12] Written octets only take effect at a load pulse.
// [RL13] Host starts write bursts at addresses 0 to 21.
// [RL14] Device never drives the data line during a write sequence.
// [RL15] Sequence opens with seven address bits MSB first, then direction bit.
// [RL16] Data octets MSB first to incrementing addresses, one to twenty-two.
// [RL17] Select active high; data sampled on falling serial clock edges.
// [RL18] Select falling after a write produces the internal load pulse.
// [RL19] No load pulse while load-enable bit 0 of register zero is clear.
// [RL20] Read sequences (direction bit one) leave all registers unchanged.
// [RL21] Write octets aimed beyond address 21 are discarded.
// [RL22] Select rising clears the bit and octet position to the address field.
`timescale 1ns/1ps
`default_nettype none
`include "rcrb_regs.svh"

module rcrb_bank #(
  parameter logic [1:0] PD_MODE = 2'b00
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ctrlSclk,
  input wire logic ctrlCs,
  input wire logic ctrlIoIn,
  output logic ctrlIoOut,
  output logic ctrlIoOe,
  input wire rcrb_pkg::rcrb_byte_t freqErrResult,
  output logic [`RCRB_NUM_WR_REGS*`RCRB_REG_WIDTH-1:0] cfgRegs,
  output logic loadPulse
);
  import rcrb_pkg::*;

  rcrb_state_t stQ;
  rcrb_state_t st_d;
  logic [2:0] pinsSync;
  logic sclkS;
  logic csS;
  logic ioS;
  logic sclkFall;
  logic csRise;
  logic csFall;

  // Next address, held at the top so a long burst cannot wrap onto register 0
  function automatic rcrb_addr_t next_addr(input rcrb_addr_t a);
    if (a == `RCRB_ADDR_SATURATE)
      return a;
    else
      return 7'(a + 7'h01);
  endfunction

  // Value returned for a read address; nonexistent addresses read as fill
  function automatic rcrb_byte_t read_byte(input rcrb_regs_t regs, input rcrb_byte_t result, input rcrb_addr_t a);
    if (a <= `RCRB_LAST_WR_ADDR)
      return regs[a[4:0]];
    else if (a == `RCRB_FREQ_ERROR_RESULT)
      return result;
    else
      return `RCRB_READ_FILL;
  endfunction

  // All three pins come from the host's domain, so they share one synchroniser
  rcrb_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .asyncIn({ctrlSclk, ctrlCs, ctrlIoIn}), // RL6
    .syncOut(pinsSync)
  );

  assign sclkS = pinsSync[2];
  assign csS = pinsSync[1];
  assign ioS = pinsSync[0];

  // Edges seen on synchronised copies; data and clock share the same delay
  assign sclkFall = stQ.sclkPrev & ~sclkS; // RL17
  assign csRise = csS & ~stQ.csPrev; // RL17
  assign csFall = ~csS & stQ.csPrev;

  // Sequence engine: select edges take priority over serial clock edges
  always_comb
  begin
    st_d = stQ;
    st_d.sclkPrev = sclkS;
    st_d.csPrev = csS;
    st_d.loadPulse = 1'b0;
    if (csRise)
    begin
      st_d.phase = PH_ADDR; // RL22
      st_d.bitCnt = 3'h0; // RL22
      st_d.ioOe = 1'b0;
      st_d.wrote = 1'b0;
    end
    else if (csFall)
    begin
      st_d.phase = PH_IDLE;
      st_d.ioOe = 1'b0;
      // Load only after a write and only with load enable set
      if (stQ.wrote && stQ.shadow[0][`RCRB_LOAD_EN_BIT])
      begin
        st_d.loadPulse = 1'b1; // RL18 RL19
        st_d.active = stQ.shadow; // RL12
      end
    end
    else if (csS && sclkFall)
    begin
      // Falling edges outside select never get here, so a shared bus is harmless
      st_d.rxShift = {stQ.rxShift[6:0], ioS}; // RL9 RL15
      st_d.bitCnt = 3'(stQ.bitCnt + 3'h1); // RL3
      case (stQ.phase)
        PH_ADDR:
        begin
          if (stQ.bitCnt == `RCRB_LAST_BIT)
          begin
            st_d.addr = stQ.rxShift[6:0]; // RL15
            if (ioS)
            begin
              // Direction bit one: turn the data line round and present the first octet
              st_d.phase = PH_READ;
              st_d.ioOe = 1'b1;
              st_d.txShift = read_byte(stQ.shadow, freqErrResult, stQ.rxShift[6:0]); // RL2
            end
            else
            begin
              st_d.phase = PH_WRITE; // RL14
            end
          end
        end
        PH_WRITE:
        begin
          if (stQ.bitCnt == `RCRB_LAST_BIT)
          begin
            // Octets past register 21 are dropped, protecting the read-only result
            if (stQ.addr <= `RCRB_LAST_WR_ADDR)
            begin
              st_d.shadow[stQ.addr[4:0]] = {stQ.rxShift[6:0], ioS}; // RL16 RL21
              st_d.wrote = 1'b1;
            end
            st_d.addr = next_addr(stQ.addr); // RL16
          end
        end
        PH_READ:
        begin
          if (stQ.bitCnt == `RCRB_LAST_BIT)
          begin
            st_d.addr = next_addr(stQ.addr);
            st_d.txShift = read_byte(stQ.shadow, freqErrResult, next_addr(stQ.addr)); // RL20
          end
          else
          begin
            st_d.txShift = {stQ.txShift[6:0], 1'b0}; // RL3
          end
        end
        default:
        begin
          st_d.phase = PH_IDLE;
        end
      endcase
    end
  end

  // State register; reset leaves both register copies in power-down mode
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      stQ <= '0;
      stQ.shadow[0][`RCRB_MODE_MSB:`RCRB_MODE_LSB] <= PD_MODE; // RL10
      stQ.active[0][`RCRB_MODE_MSB:`RCRB_MODE_LSB] <= PD_MODE; // RL10
    end
    else
    begin
      stQ <= st_d;
    end
  end

  // Outputs straight from flip-flops; the mask hides don't-care bits
  assign ctrlIoOut = stQ.txShift[7];
  assign ctrlIoOe = stQ.ioOe; // RL14
  assign loadPulse = stQ.loadPulse;
  assign cfgRegs = stQ.active & `RCRB_USED_MASK; // RL4 RL1

  // Checks kept next to the engine they guard
  a_write_no_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (stQ.phase != PH_READ) |-> !ctrlIoOe) // RL14
    else $error("data line driven outside a read");

  a_idle_sclk_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!csS && !stQ.csPrev) |=> ($stable(stQ.bitCnt) && $stable(stQ.shadow) && $stable(stQ.addr))) // RL8
    else $error("serial clock acted without select");

  a_cs_start_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    csRise |=> (stQ.bitCnt == 3'h0 && stQ.phase == PH_ADDR && !stQ.wrote)) // RL22
    else $error("select did not restart the sequence");

  a_load_on_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (csFall && stQ.wrote && stQ.shadow[0][`RCRB_LOAD_EN_BIT]) |=> (loadPulse ##1 !loadPulse)) // RL18
    else $error("missing or long load pulse after write");

  a_load_needs_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    loadPulse |-> ($past(csFall) && $past(stQ.shadow[0][`RCRB_LOAD_EN_BIT]) && $past(stQ.wrote))) // RL19
    else $error("load pulse without enable or write");

  a_active_on_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(stQ.active) |-> (loadPulse && stQ.active == $past(stQ.shadow))) // RL12
    else $error("configuration changed without load");

  a_read_keeps_regs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (stQ.phase == PH_READ) |=> $stable(stQ.shadow)) // RL20
    else $error("read sequence altered a register");

  a_write_in_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(stQ.shadow) |-> ($past(stQ.addr) <= `RCRB_LAST_WR_ADDR && $past(stQ.phase) == PH_WRITE
      && $past(stQ.bitCnt) == `RCRB_LAST_BIT)) // RL21
    else $error("write outside registers 0 to 21");

  a_reset_power_down: assert property (@(posedge sys_clk)
    !rst_n |=> (stQ.active[0][`RCRB_MODE_MSB:`RCRB_MODE_LSB] == PD_MODE && !loadPulse)) // RL10
    else $error("reset did not select power-down");

  a_read_first_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (csS && sclkFall && stQ.phase == PH_ADDR && stQ.bitCnt == `RCRB_LAST_BIT && ioS)
      |=> (ctrlIoOe && ctrlIoOut == read_byte(stQ.shadow, freqErrResult, stQ.addr) >> 7)) // RL2
    else $error("read did not present the addressed octet");

  // Load pulse shape and its preconditions
  a_load_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL18
    loadPulse
      |=> !loadPulse)
    else $error("load pulse longer than one cycle");

  a_load_needs_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL12
    (csFall && !stQ.wrote)
      |=> !loadPulse)
    else $error("load pulse without a completed write octet");

  a_no_load_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL20
    (csFall && stQ.phase == PH_READ)
      |=> !loadPulse)
    else $error("read sequence produced a load pulse");

  // Turnaround of the shared data line and address capture; a late release would fight the host
  a_oe_off_release: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL14
    csFall
      |=> !ctrlIoOe)
    else $error("data line still driven after select fell");

  a_oe_under_select: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL9
    ctrlIoOe
      |-> (csS || stQ.csPrev))
    else $error("data line driven without own select");

  a_read_holds_oe: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL14
    (stQ.phase == PH_READ)
      |-> ctrlIoOe)
    else $error("read phase without data line drive");

  a_write_entry: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL15
    (csS && sclkFall && stQ.phase == PH_ADDR && stQ.bitCnt == `RCRB_LAST_BIT && !ioS)
      |=> (stQ.phase == PH_WRITE && !ctrlIoOe))
    else $error("direction bit zero did not open a write");

  a_addr_capture: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL15
    (csS && sclkFall && stQ.phase == PH_ADDR && stQ.bitCnt == `RCRB_LAST_BIT)
      |=> (stQ.addr == $past(stQ.rxShift[6:0])))
    else $error("address field not captured MSB first");

  // Bit position and read shifting
  a_bitcnt_advance: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL3
    (csS && sclkFall && stQ.phase != PH_IDLE)
      |=> (stQ.bitCnt == $past(stQ.bitCnt) + 3'h1))
    else $error("bit position did not advance on a falling edge");

  a_tx_shift: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL3
    (csS && sclkFall && stQ.phase == PH_READ && stQ.bitCnt != `RCRB_LAST_BIT)
      |=> (ctrlIoOut == $past(stQ.txShift[6])))
    else $error("read octet not shifted MSB first");

  // Nothing is written while no sequence is open
  a_idle_no_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL8
    (stQ.phase == PH_IDLE)
      |=> $stable(stQ.shadow))
    else $error("register written outside a sequence");

endmodule

`default_nettype wire

// ==== test/rcrb_host_model.sv ====
// Host model: drives the three-wire control port (serial clock, data, select).
// Assumes the bench clock on sys_clk; one serial bit spans 8 sys_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module rcrb_host_model (
  input wire logic sys_clk,
  input wire logic pinIo,
  output logic sclk,
  output logic cs,
  output logic hostIo,
  output logic hostOe
);
  import rcrb_pkg::*;

  // Serial clock stands low between frames
  initial
  begin
    sclk = 1'b0;
    cs = 1'b0;
    hostIo = 1'b0;
    hostOe = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // MSB first; data changes while the clock is high, ahead of the fall
  task automatic shift(input rcrb_byte_t b, input int nb, input bit rel);
    for (int i = 7; i > 7 - nb; i--)
    begin
      sclk = 1'b1;
      hostIo = b[i];
      tick(4);
      sclk = 1'b0;
      tick(2);
      // Hold two cycles past the fall so the sampled bit is safe
      if (rel && i == 0)
      begin
        hostOe = 1'b0;
        hostIo = ~hostIo;
      end
      tick(2);
    end
  endtask

  // Burst of n octets, then extra bits of a partial octet
  task automatic wr(input rcrb_addr_t a, input rcrb_byte_t d[23], input int n, input int extra);
    cs = 1'b1;
    tick(4);
    shift({a, 1'b0}, 8, 1'b0);
    for (int k = 0; k < n; k++)
      shift(d[k], 8, 1'b0);
    shift(8'hff, extra, 1'b0);
    cs = 1'b0;
    tick(8);
  endtask

  // Host samples each read bit on the rising serial clock
  task automatic rd(input rcrb_addr_t a, input int n, output rcrb_byte_t q[23]);
    cs = 1'b1;
    tick(4);
    shift({a, 1'b1}, 8, 1'b1);
    for (int k = 0; k < n; k++)
      for (int i = 7; i >= 0; i--)
      begin
        sclk = 1'b1;
        q[k][i] = pinIo;
        tick(4);
        sclk = 1'b0;
        tick(4);
      end
    cs = 1'b0;
    tick(8);
    hostOe = 1'b1;
  endtask

  // Bus traffic meant for another device: select stays low
  task automatic noise();
    for (int i = 0; i < 8; i++)
    begin
      sclk = ~sclk;
      hostIo = ~hostIo;
      tick(4);
    end
  endtask
endmodule
`default_nettype wire

// ==== test/radio_config_register_bank_tb_top.sv ====
// Self-checking bench of the register bank, driven through the host model.
// Assumes a 40 MHz sys_clk and the host model's serial tasks.
`timescale 1ns/1ps
`default_nettype none
`include "rcrb_regs.svh"
module radio_config_register_bank_tb_top;
  import rcrb_pkg::*;
  localparam logic [1:0] PD = 2'b10;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, cs, hostIo, hostOe, ioOut, ioOe, loadPulse;
  logic [175:0] cfg, prevCfg, expCfg;
  rcrb_byte_t fe = 8'h5a;
  rcrb_byte_t d[23], q[23];
  int fail_count = 0;
  int total_checks = 0;
  int loadCnt = 0;
  wire logic pin = ioOe ? ioOut : hostIo;

  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  rcrb_bank #(.PD_MODE(PD)) i_rcrb_bank (.sys_clk(sys_clk), .rst_n(rst_n), .ctrlSclk(sclk),
    .ctrlCs(cs), .ctrlIoIn(pin), .ctrlIoOut(ioOut), .ctrlIoOe(ioOe), .freqErrResult(fe),
    .cfgRegs(cfg), .loadPulse(loadPulse));
  rcrb_host_model i_rcrb_host_model (.sys_clk(sys_clk), .pinIo(pin), .sclk(sclk), .cs(cs),
    .hostIo(hostIo), .hostOe(hostOe));

  task automatic chkB(input rcrb_byte_t got, input rcrb_byte_t exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkW(input logic [175:0] got, input logic [175:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Config may move only with a load pulse; no contention on the data line
  always @(negedge sys_clk)
  begin
    if (rst_n && cfg !== prevCfg)
      chkB({7'h0, loadPulse}, 8'h01);
    if (rst_n && hostOe && ioOe !== 1'b0)
      chkB({7'h0, ioOe}, 8'h00);
    loadCnt += (loadPulse === 1'b1);
    prevCfg = cfg;
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    expCfg = '0;
    expCfg[2:1] = PD;
    chkW(cfg, expCfg);
    i_rcrb_host_model.rd(7'h00, 23, q);
    for (int i = 0; i < 23; i++)
      chkB(q[i], i == 0 ? {5'h0, PD, 1'b0} : i == 22 ? fe : 8'h00);
    $display("test reset_read done");
    for (int i = 0; i < 23; i++)
      d[i] = {i[3:0], ~i[3:0]};
    d[20] = 8'ha3;
    i_rcrb_host_model.wr(7'h00, d, 22, 0);
    for (int i = 0; i < 22; i++)
      expCfg[8*i +: 8] = d[i];
    expCfg &= `RCRB_USED_MASK;
    chkW(cfg, expCfg);
    i_rcrb_host_model.rd(7'h13, 6, q);
    for (int i = 0; i < 6; i++)
      chkB(q[i], i < 3 ? d[19+i] : i == 3 ? fe : 8'h00);
    chkB(loadCnt[7:0], 8'h01);
    $display("test full_write done");
    // Load disabled, overrun past 21 with a trailing partial octet
    q[0] = 8'h0e;
    i_rcrb_host_model.wr(7'h00, q, 1, 0);
    q[0] = 8'h0c;
    q[1] = 8'hff;
    q[2] = 8'hee;
    i_rcrb_host_model.wr(7'h15, q, 3, 3);
    i_rcrb_host_model.noise();
    chkB(loadCnt[7:0], 8'h01);
    q[0] = 8'h0f;
    i_rcrb_host_model.wr(7'h00, q, 1, 0);
    chkB(loadCnt[7:0], 8'h02);
    expCfg[175:168] = 8'h0c;
    expCfg &= `RCRB_USED_MASK;
    chkW(cfg, expCfg);
    i_rcrb_host_model.rd(7'h14, 3, q);
    chkB(q[0], 8'ha3);
    chkB(q[1], 8'h0c);
    chkB(q[2], fe);
    $display("test load_control done");
    end_sim();
  end
endmodule
`default_nettype wire
